// ### verilog/iesc_regs.svh
/*
 * Register offsets, field positions and reset values of the interrupt
 * enable set/clear block. Assumes a 4-bit classic Wishbone byte address.
 */
`ifndef IESC_REGS_SVH
`define IESC_REGS_SVH

`define IESC_ADDR_W 4
`define IESC_OFS_SET_LOW 4'h0
`define IESC_OFS_SET_HIGH 4'h4
`define IESC_OFS_CLR_LOW 4'h8
`define IESC_OFS_CLR_HIGH 4'hc
`define IESC_NUM_SRC 50
`define IESC_LOW_W 32
`define IESC_HIGH_W 18
`define IESC_LOW_LSB 0
`define IESC_HIGH_LSB 32
`define IESC_ENABLE_RST 50'h0
`define IESC_UNMAPPED_DATA 32'h0

`endif

// ### verilog/iesc_pkg.sv
/*
 * Types shared by the interrupt enable set/clear block.
 * Assumes the offsets header is compiled alongside.
 */
package iesc_pkg;
    typedef logic [49:0] iesc_src_t;

    typedef enum logic [1:0] {
        IESC_SEL_SET_LOW = 2'b00,
        IESC_SEL_SET_HIGH = 2'b01,
        IESC_SEL_CLR_LOW = 2'b10,
        IESC_SEL_CLR_HIGH = 2'b11
    } iesc_sel_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [3:0] adr;
        logic [31:0] dat;
    } iesc_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } iesc_wb_rsp_s;
endpackage

// ### verilog/iesc_top.sv
/*
 * Interrupt enable set/clear block: one enable flop per source for 50
 * sources, reached through set-view and clear-view words over classic
 * Wishbone, gating the peripheral request lines.
 * Assumes requests come from logic on clk_i; a single synchronous reset.
 * Limitation: the request lines are not synchronised, so a source from
 * another clock domain must be brought onto clk_i before it reaches here.
 * Trade-off: gating is combinational, so a request passes in its own cycle
 * but an enable write only takes hold from the cycle after the ack edge.
 */
// Design decisions made here: register access over Wishbone and the address map.
//
// Operation
// - Writing one to a set-view bit enables that source.
// - Writing zero to a set-view bit leaves that enable unchanged.
// - Reading a set-view word returns enable state, one meaning enabled.
// - Low word bit n is source n; high word bit n is source 32+n.
// - High word holds bits 17..0; 31..18 read zero; all enables reset zero.
// - Low clear-view word covers sources 31..0 and resets to zero.
// - Clear-view one disables, zero does nothing, read returns enable state.
//
`timescale 1ns/1ps
`default_nettype none
`include "iesc_regs.svh"

module iesc_top
    import iesc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire iesc_wb_req_s wb_req_i,
    output iesc_wb_rsp_s wb_rsp_o,
    input wire iesc_src_t irq_req_i,
    output iesc_src_t irq_gated_o,
    output iesc_src_t enable_state_o
);

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    function automatic logic [3:0] word_of(input logic [3:0] adr);
        word_of = {adr[3:2], 2'b00};
    endfunction

    // Byte lane expansion of sel, so a partial write touches only its bytes
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    iesc_src_t enable_r;
    wire iesc_src_t enable_nxt;
    logic ack_r;
    logic [31:0] rdata_r;

    wire logic access = wb_req_i.cyc && wb_req_i.stb && !ack_r;
    wire logic wr_take = access && wb_req_i.we;
    wire logic [3:0] word_adr = word_of(wb_req_i.adr);
    wire logic [31:0] wdata = wb_req_i.dat & lane_mask(wb_req_i.sel);

    wire logic hit_set_low = word_adr == `IESC_OFS_SET_LOW;
    wire logic hit_set_high = word_adr == `IESC_OFS_SET_HIGH;
    wire logic hit_clr_low = word_adr == `IESC_OFS_CLR_LOW;
    wire logic hit_clr_high = word_adr == `IESC_OFS_CLR_HIGH;

    // ****************************************************************
    // Set and clear masks over the whole source vector
    // ****************************************************************
    wire iesc_src_t wide_low = {18'h0, wdata};
    wire iesc_src_t wide_high = {wdata[17:0], 32'h0};

    wire iesc_src_t set_mask = !wr_take ? 50'h0 :
        hit_set_low ? wide_low : hit_set_high ? wide_high : 50'h0;
    wire iesc_src_t clr_mask = !wr_take ? 50'h0 :
        hit_clr_low ? wide_low : hit_clr_high ? wide_high : 50'h0;

    // ****************************************************************
    // Next enable state, one slice per source
    // ****************************************************************
    // One shared flop per source; set and clear sit at different words, so
    // they never meet on one source in a cycle
    genvar src;
    generate
        for (src = 0; src < `IESC_NUM_SRC; src = src + 1) begin : g_src
            assign enable_nxt[src] = (enable_r[src] | set_mask[src]) & ~clr_mask[src];

            chk_src_set: assert property (@(posedge clk_i) disable iff (rst_i)
                set_mask[src] |=> enable_r[src])
                else $error("set bit did not enable its source");

            chk_src_clear: assert property (@(posedge clk_i) disable iff (rst_i)
                clr_mask[src] |=> !enable_r[src])
                else $error("clear bit did not disable its source");

            chk_src_gate: assert property (@(posedge clk_i) disable iff (rst_i)
                !enable_r[src] |-> !irq_gated_o[src])
                else $error("request passed a disabled source");
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= `IESC_ENABLE_RST;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Both views read the same enable state; unused high bits are zero
    wire logic [31:0] view_low = enable_r[31:0];
    wire logic [31:0] view_high = {14'h0, enable_r[49:32]};
    wire logic [31:0] rd_mux = (hit_set_low || hit_clr_low) ? view_low :
        (hit_set_high || hit_clr_high) ? view_high : `IESC_UNMAPPED_DATA;

    // Ack lands one cycle after the strobe and drops the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= access;
            rdata_r <= (access && !wb_req_i.we) ? rd_mux : 32'h0;
        end
    end

    assign wb_rsp_o.ack = ack_r;
    assign wb_rsp_o.dat = rdata_r;

    // ****************************************************************
    // Request gating
    // ****************************************************************
    // Combinational so a request is not delayed; enable is a flop
    assign irq_gated_o = irq_req_i & enable_r;
    assign enable_state_o = enable_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_set_enables: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_low && wdata[5] |=> enable_r[5])
        else $error("set-view one did not enable source 5");

    chk_set_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_low && !wdata[0] |=> enable_r[0] == $past(enable_r[0]))
        else $error("set-view zero changed source 0");

    chk_read_state: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && hit_set_low && !wr_take
        |=> wb_rsp_o.dat == $past(enable_r[31:0]))
        else $error("set-view low read does not match enable state");

    chk_high_map: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_high && wdata[17] |=> enable_r[49])
        else $error("high word bit 17 did not map to source 49");

    chk_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_rsp_o.ack && $past(hit_set_high) |-> wb_rsp_o.dat[31:18] == 14'h0)
        else $error("high word reserved bits not zero");

    chk_reset_zero: assert property (@(posedge clk_i)
        rst_i |=> enable_r == 50'h0 && !wb_rsp_o.ack)
        else $error("enables not zero after reset");

    chk_clr_disables: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_clr_low && wdata[3] |=> !enable_r[3] ##1 !irq_gated_o[3])
        else $error("clear-view one did not disable source 3");

    chk_gate_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_gated_o[40] |-> irq_req_i[40] && enable_r[40])
        else $error("request passed while disabled");

    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        access |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not one cycle after strobe");

    // ****************************************************************
    // Bus timing helper
    // ****************************************************************
    // Counts cycles a strobe has waited; the slave answers in one, so a
    // count past one means a lost or late ack
    logic [1:0] wait_cnt_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_cnt_r <= 2'h0;
        end else if (!access) begin
            wait_cnt_r <= 2'h0;
        end else if (wait_cnt_r != 2'h3) begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
        end
    end

    chk_wait_bound: assert property (@(posedge clk_i) disable iff (rst_i)
        wait_cnt_r <= 2'h1)
        else $error("strobe waited more than one cycle");

    chk_ack_has_req: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_rsp_o.ack
        |-> $past(access))
        else $error("ack without a taken request");

    // ****************************************************************
    // Checks on the write path
    // ****************************************************************
    chk_clr_high_map: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_clr_high && wdata[17]
        |=> !enable_r[49])
        else $error("clear high bit 17 did not disable source 49");

    chk_low_map_top: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_low && wdata[31]
        |=> enable_r[31])
        else $error("low word bit 31 did not map to source 31");

    chk_high_spares_low: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_high
        |=> enable_r[31:0] == $past(enable_r[31:0]))
        else $error("high word write changed low sources");

    chk_low_spares_high: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_low
        |=> enable_r[49:32] == $past(enable_r[49:32]))
        else $error("low word write changed high sources");

    chk_clr_spares_high: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_clr_low
        |=> enable_r[49:32] == $past(enable_r[49:32]))
        else $error("low clear write changed high sources");

    chk_clr_zero_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_clr_low && !wdata[0]
        |=> enable_r[0] == $past(enable_r[0]))
        else $error("clear-view zero changed source 0");

    chk_idle_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_take
        |=> enable_r == $past(enable_r))
        else $error("enables changed without a write");

    chk_lane_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_low && !wb_req_i.sel[3]
        |=> enable_r[31:24] == $past(enable_r[31:24]))
        else $error("unselected byte lane changed enables");

    // ****************************************************************
    // Checks on the read path
    // ****************************************************************
    chk_clr_read_state: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && hit_clr_low
        |=> wb_rsp_o.dat == $past(enable_r[31:0]))
        else $error("clear-view low read does not match enable state");

    chk_high_read_state: assert property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && hit_set_high
        |=> wb_rsp_o.dat == {14'h0, $past(enable_r[49:32])})
        else $error("set-view high read does not match enable state");

    chk_write_dat_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        access && wb_req_i.we
        |=> wb_rsp_o.dat == 32'h0)
        else $error("write answer carried nonzero data");

    // ****************************************************************
    // Checks around reset and gating
    // ****************************************************************
    chk_reset_gated: assert property (@(posedge clk_i)
        rst_i
        |=> irq_gated_o == 50'h0)
        else $error("request passed during reset");

    chk_reset_read_zero: assert property (@(posedge clk_i)
        rst_i
        |=> wb_rsp_o.dat == 32'h0 && enable_state_o == 50'h0)
        else $error("outputs not zero after reset");

    cov_set_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_set_high);
    cov_clr_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_take && hit_clr_high);
    cov_read: cover property (@(posedge clk_i) disable iff (rst_i)
        access && !wb_req_i.we && hit_clr_low);
    cov_gate: cover property (@(posedge clk_i) disable iff (rst_i)
        |irq_gated_o);

    cov_lane_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_take && wb_req_i.sel != 4'hf);

endmodule // iesc_top
`default_nettype wire

// ### tb/iesc_irq_src.sv
/*
 * Model of the peripheral request lines: level requests on the system clock.
 * Assumes the bench sets the wanted request pattern on pat_i.
 */
`timescale 1ns/1ps
`default_nettype none
module iesc_irq_src
    import iesc_pkg::*;
(
    input wire logic clk_i,
    input wire iesc_src_t pat_i,
    output iesc_src_t irq_req_o
);
    // Registered, as a peripheral flop would drive it
    always_ff @(posedge clk_i) begin
        irq_req_o <= pat_i;
    end
endmodule // iesc_irq_src
`default_nettype wire

// ### tb/interrupt_enable_set_clear_bench.sv
/*
 * Self-checking bench for iesc_top over classic Wishbone.
 * Assumes the package and offsets header are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "iesc_regs.svh"
module interrupt_enable_set_clear_bench
    import iesc_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    iesc_wb_req_s req = '0;
    iesc_wb_rsp_s rsp;
    iesc_src_t pat = '0;
    iesc_src_t irq;
    iesc_src_t gated;
    iesc_src_t state;
    int mismatches = 0;
    int n_tests = 0;
    always #4 clk_i = ~clk_i;
    iesc_irq_src src_u (.clk_i(clk_i), .pat_i(pat), .irq_req_o(irq));
    iesc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .irq_req_i(irq), .irq_gated_o(gated), .enable_state_o(state));
    // ****************
    // Bus and checks
    // ****************
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, s, a, d};
        do @(posedge clk_i); while (rsp.ack !== 1'b1);
        q = rsp.dat;
        req <= '0;
    endtask
    task automatic chk(input string n, input logic [49:0] e, input logic [49:0] g);
        n_tests++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hf, q);
        chk("read data", {18'h0, e}, {18'h0, q});
    endtask
    task automatic wr_lane(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        bus(1'b1, a, d, s, q);
        chk("write data", 50'h0, {18'h0, q});
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        wr_lane(a, d, 4'hf);
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_reset();
        pat <= '1;
        rd(`IESC_OFS_SET_LOW, 32'h0);
        rd(`IESC_OFS_SET_HIGH, 32'h0);
        rd(`IESC_OFS_CLR_LOW, 32'h0);
        chk("gated", 50'h0, gated);
        $display("test reset done");
    endtask
    task automatic t_set();
        wr(`IESC_OFS_SET_LOW, 32'h8000_0001);
        wr(`IESC_OFS_SET_HIGH, 32'hfffe_0001);
        wr(`IESC_OFS_SET_LOW, 32'h0);
        rd(`IESC_OFS_SET_LOW, 32'h8000_0001);
        rd(`IESC_OFS_SET_HIGH, 32'h0002_0001);
        chk("state", 50'h2_0001_8000_0001, state);
        chk("gated", 50'h2_0001_8000_0001, gated);
        $display("test set done");
    endtask
    task automatic t_clear();
        wr(`IESC_OFS_CLR_LOW, 32'h0000_0001);
        wr(`IESC_OFS_CLR_HIGH, 32'h0002_0000);
        rd(`IESC_OFS_CLR_LOW, 32'h8000_0000);
        rd(`IESC_OFS_SET_HIGH, 32'h0000_0001);
        pat <= 50'h1_0000_0000;
        repeat (2) @(posedge clk_i);
        chk("gated", 50'h1_0000_0000, gated);
        $display("test clear done");
    endtask
    task automatic t_lanes_reset();
        wr_lane(`IESC_OFS_SET_LOW, 32'hffff_ffff, 4'h2);
        rd(`IESC_OFS_SET_LOW, 32'h8000_ff00);
        wr(`IESC_OFS_CLR_HIGH, 32'h0000_0001);
        rd(`IESC_OFS_CLR_HIGH, 32'h0000_0000);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`IESC_OFS_SET_LOW, 32'h0);
        chk("state", 50'h0, state);
        chk("gated", 50'h0, gated);
        $display("test lanes and reset done");
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_set();
        t_clear();
        t_lanes_reset();
        end_sim();
    end
    // Whole run needs about 76 cycles; far more means a missing ack
    initial begin
        repeat (3000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
endmodule // interrupt_enable_set_clear_bench
`default_nettype wire
